// File: hdl/dsprst_top.sv
// Reset sequencer, bus pin control and flag pin control with APB registers
`timescale 1ns/100ps
module dsprst_top #(
	parameter int PADDR_W = dsprst_pkg::REG_AW
) (
	// Clock, reset, enable
	input  wire logic                                  clk,
	input  wire logic                                  rst,
	input  wire logic                                  ce,
	// Device reset, hold and mode pins
	input  wire logic                                  resetN,
	input  wire logic                                  holdN,
	input  wire logic                                  mcMode,
	output logic                                       holdAckN,
	// APB slave
	input  wire logic                                  psel,
	input  wire logic                                  penable,
	input  wire logic                                  pwrite,
	input  wire logic [PADDR_W-1:0]                    paddr,
	input  wire logic [31:0]                           pwdata,
	output logic      [31:0]                           prdata,
	output logic                                       pready,
	output logic                                       pslverr,
	// General flag pins
	input  wire logic [dsprst_pkg::FLAG_PINS-1:0]      flagIn,
	output logic      [dsprst_pkg::FLAG_PINS-1:0]      flagOut,
	output logic      [dsprst_pkg::FLAG_PINS-1:0]      flagOe,
	// Serial and timer pins, driven by the peripherals
	input  wire logic [dsprst_pkg::ASYNC_PINS-1:0]     perOut,
	input  wire logic [dsprst_pkg::ASYNC_PINS-1:0]     perOe,
	output logic      [dsprst_pkg::ASYNC_PINS-1:0]     asyncOut,
	output logic      [dsprst_pkg::ASYNC_PINS-1:0]     asyncOe,
	// Interrupt acknowledge
	input  wire logic                                  iackReq,
	output logic                                       iackN,
	// Primary bus
	output logic      [23:0]                           pAddr,
	output logic                                       pAddrOe,
	input  wire logic [31:0]                           pDataIn,
	output logic      [31:0]                           pDataOut,
	output logic                                       pDataOe,
	output logic                                       pRw,
	output logic                                       pRwOe,
	output logic                                       strobeN,
	output logic                                       mStrobeN,
	output logic                                       ioStrobeN,
	// Expansion bus
	output logic      [12:0]                           xAddr,
	output logic                                       xAddrOe,
	output logic      [31:0]                           xDataOut,
	output logic                                       xDataOe,
	output logic                                       xRw,
	output logic                                       xRwOe
);
	dsprst_phase_if ph ();

	dsprst_phase_gen u_phase (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.ph  (ph)
	);

	dsprst_pkg::dsprst_state_t state;
	dsprst_pkg::dsprst_state_t next_state;

	logic        resetMeta;
	logic        resetSync;
	logic        holdMeta;
	logic        holdSync;
	logic [3:0]  lowCnt;
	logic [1:0]  fetchCnt;
	logic [2:0]  waitCnt;
	logic [2:0]  fetchWaits;
	logic [7:0]  ioFlag;
	logic [2:0]  pBusCtl;
	logic [2:0]  xBusCtl;
	logic [31:0] vector;
	logic        holdGrant;
	logic        inReset;
	logic        apbWrite;
	logic        apbSetup;

	// Known register offset
	function automatic logic addrHit(input logic [PADDR_W-1:0] a);
		addrHit = (a == dsprst_pkg::OFS_IOFLAG)  || (a == dsprst_pkg::OFS_PBUSCTL) ||
		          (a == dsprst_pkg::OFS_XBUSCTL) || (a == dsprst_pkg::OFS_STATUS)  ||
		          (a == dsprst_pkg::OFS_VECTOR);
	endfunction : addrHit

	assign inReset  = ~resetSync;
	assign apbSetup = psel & ~penable;
	assign apbWrite = psel & penable & pready & pwrite & addrHit(paddr);

	// Two-flop synchronisers for reset and hold pins
	always_ff @(posedge clk) begin
		if (rst) begin
			resetMeta <= 1'b0;
			resetSync <= 1'b0;
			holdMeta  <= 1'b1;
			holdSync  <= 1'b1;
		end else if (ce) begin
			resetMeta <= resetN;
			resetSync <= resetMeta;
			holdMeta  <= holdN;
			holdSync  <= holdMeta;
		end
	end

	// Wait states used for the vector fetches
	always_comb begin
		if (mcMode) begin
			fetchWaits = dsprst_pkg::WAIT_MCMODE;
		end else begin
			fetchWaits = pBusCtl;
		end
	end

	// Sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			dsprst_pkg::ST_RESET: begin
				if (ph.h1Fall && resetSync && lowCnt >= dsprst_pkg::RESET_MIN_H1) begin
					next_state = dsprst_pkg::ST_FETCH;
				end
			end
			dsprst_pkg::ST_FETCH: begin
				if (ph.h3Rise && waitCnt == fetchWaits) begin
					if (fetchCnt == dsprst_pkg::VECTOR_FETCHES - 2'h1) begin
						next_state = dsprst_pkg::ST_RUN;
					end else begin
						next_state = dsprst_pkg::ST_GAP;
					end
				end
			end
			dsprst_pkg::ST_GAP: begin
				if (ph.h3Rise && holdSync) begin
					next_state = dsprst_pkg::ST_FETCH;
				end
			end
			dsprst_pkg::ST_RUN: begin
				next_state = dsprst_pkg::ST_RUN;
			end
			default: begin
				next_state = dsprst_pkg::ST_RESET;
			end
		endcase
		if (inReset) begin
			next_state = dsprst_pkg::ST_RESET;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= dsprst_pkg::ST_RESET;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// Reset low time, wait and fetch counters
	always_ff @(posedge clk) begin
		if (rst) begin
			lowCnt   <= 4'h0;
			waitCnt  <= 3'h0;
			fetchCnt <= 2'h0;
		end else if (ce) begin
			if (state != dsprst_pkg::ST_RESET) begin
				lowCnt <= 4'h0;
			end else if (ph.h1Fall && lowCnt < dsprst_pkg::RESET_MIN_H1) begin
				lowCnt <= lowCnt + 4'h1;
			end
			if (state != dsprst_pkg::ST_FETCH) begin
				waitCnt <= 3'h0;
			end else if (ph.h3Rise && waitCnt != fetchWaits) begin
				waitCnt <= waitCnt + 3'h1;
			end
			if (state == dsprst_pkg::ST_RESET) begin
				fetchCnt <= 2'h0;
			end else if (state == dsprst_pkg::ST_FETCH && next_state != dsprst_pkg::ST_FETCH) begin
				fetchCnt <= fetchCnt + 2'h1;
			end
		end
	end

	// Fetched reset vector
	always_ff @(posedge clk) begin
		if (rst) begin
			vector <= 32'h00000000;
		end else if (ce) begin
			if (state == dsprst_pkg::ST_FETCH && next_state != dsprst_pkg::ST_FETCH) begin
				vector <= pDataIn;
			end
		end
	end

	// Hold grant, taken in reset too but never inside a fetch
	always_ff @(posedge clk) begin
		if (rst) begin
			holdGrant <= 1'b0;
			holdAckN  <= 1'b1;
		end else if (ce) begin
			if (!holdSync && state != dsprst_pkg::ST_FETCH) begin
				holdGrant <= 1'b1;
				holdAckN  <= 1'b0;
			end else if (holdSync) begin
				holdGrant <= 1'b0;
				holdAckN  <= 1'b1;
			end
		end
	end

	// Bus control registers
	always_ff @(posedge clk) begin
		if (rst) begin
			pBusCtl <= dsprst_pkg::WAIT_RESET;
			xBusCtl <= dsprst_pkg::WAIT_RESET;
		end else if (ce) begin
			if (inReset) begin
				pBusCtl <= dsprst_pkg::WAIT_RESET;
				xBusCtl <= dsprst_pkg::WAIT_RESET;
			end else if (apbWrite && paddr == dsprst_pkg::OFS_PBUSCTL) begin
				pBusCtl <= pwdata[dsprst_pkg::WAIT_W-1:0];
			end else if (apbWrite && paddr == dsprst_pkg::OFS_XBUSCTL) begin
				xBusCtl <= pwdata[dsprst_pkg::WAIT_W-1:0];
			end
		end
	end

	// Flag register and flag pins, one slice per pin
	for (genvar i = 0; i < dsprst_pkg::FLAG_PINS; i++) begin : g_flag
		localparam int DIR = dsprst_pkg::FLAG_DIR_POS + i * dsprst_pkg::FLAG_STRIDE;
		localparam int OUT = dsprst_pkg::FLAG_OUT_POS + i * dsprst_pkg::FLAG_STRIDE;
		localparam int INB = dsprst_pkg::FLAG_IN_POS + i * dsprst_pkg::FLAG_STRIDE;

		always_ff @(posedge clk) begin
			if (rst) begin
				ioFlag[DIR-1] <= 1'b0;
				ioFlag[DIR]   <= dsprst_pkg::IOFLAG_RESET[DIR];
				ioFlag[OUT]   <= dsprst_pkg::IOFLAG_RESET[OUT];
			end else if (ce) begin
				if (inReset) begin
					ioFlag[DIR] <= dsprst_pkg::IOFLAG_RESET[DIR];
					ioFlag[OUT] <= dsprst_pkg::IOFLAG_RESET[OUT];
				end else if (apbWrite && paddr == dsprst_pkg::OFS_IOFLAG) begin
					ioFlag[DIR] <= pwdata[DIR];
					ioFlag[OUT] <= pwdata[OUT];
				end
			end
		end

		// Input level sampled on first-phase falling edges
		always_ff @(posedge clk) begin
			if (rst) begin
				ioFlag[INB] <= dsprst_pkg::IOFLAG_RESET[INB];
			end else if (ce) begin
				if (ph.h1Fall && !flagOe[i]) begin
					ioFlag[INB] <= flagIn[i];
				end
			end
		end

		// Pin direction and value follow second-phase rising edges
		always_ff @(posedge clk) begin
			if (rst) begin
				flagOe[i]  <= 1'b0;
				flagOut[i] <= 1'b0;
			end else if (ce) begin
				if (inReset) begin
					flagOe[i] <= 1'b0;
				end else if (ph.h3Rise) begin
					flagOe[i]  <= ioFlag[DIR];
					flagOut[i] <= ioFlag[OUT];
				end
			end
		end
	end

	// Serial and timer pins float while reset is low
	always_ff @(posedge clk) begin
		if (rst) begin
			asyncOut <= '0;
			asyncOe  <= '0;
		end else if (ce) begin
			asyncOut <= perOut;
			asyncOe  <= inReset ? '0 : perOe;
		end
	end

	// Phase-one pins: data buses, read/write lines, acknowledge
	always_ff @(posedge clk) begin
		if (rst) begin
			pDataOut <= 32'h00000000;
			pDataOe  <= 1'b0;
			xDataOut <= 32'h00000000;
			xDataOe  <= 1'b0;
			pRw      <= 1'b1;
			pRwOe    <= 1'b0;
			xRw      <= 1'b1;
			xRwOe    <= 1'b0;
			iackN    <= 1'b1;
		end else if (ce && ph.h1Rise) begin
			pDataOe <= 1'b0;
			xDataOe <= 1'b0;
			if (state == dsprst_pkg::ST_RESET || holdGrant) begin
				pRwOe <= 1'b0;
			end else begin
				pRwOe <= 1'b1;
			end
			xRwOe <= state != dsprst_pkg::ST_RESET;
			pRw   <= 1'b1;
			xRw   <= 1'b1;
			iackN <= inReset ? 1'b1 : ~iackReq;
		end
	end

	// Phase-three pins: address buses and strobes
	always_ff @(posedge clk) begin
		if (rst) begin
			pAddr     <= dsprst_pkg::VECTOR_ADDR;
			pAddrOe   <= 1'b0;
			xAddr     <= 13'h0000;
			xAddrOe   <= 1'b0;
			strobeN   <= 1'b1;
			mStrobeN  <= 1'b1;
			ioStrobeN <= 1'b1;
		end else if (ce && ph.h3Rise) begin
			mStrobeN  <= 1'b1;
			ioStrobeN <= 1'b1;
			pAddr     <= dsprst_pkg::VECTOR_ADDR;
			if (next_state == dsprst_pkg::ST_RESET) begin
				pAddrOe <= 1'b0;
				xAddrOe <= 1'b0;
				strobeN <= 1'b1;
			end else begin
				pAddrOe <= ~holdGrant;
				xAddrOe <= 1'b1;
				strobeN <= ~(next_state == dsprst_pkg::ST_FETCH);
			end
		end
	end

	// APB slave, one access cycle, read data prepared in setup
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= apbSetup;
			pslverr <= apbSetup && !addrHit(paddr);
			if (apbSetup) begin
				case (paddr)
					dsprst_pkg::OFS_IOFLAG:  prdata <= {24'h000000, ioFlag};
					dsprst_pkg::OFS_PBUSCTL: prdata <= {29'h00000000, pBusCtl};
					dsprst_pkg::OFS_XBUSCTL: prdata <= {29'h00000000, xBusCtl};
					dsprst_pkg::OFS_STATUS:  prdata <= {22'h000000, state, 2'h0, fetchCnt,
					                                    1'b0, mcMode, holdGrant, inReset};
					dsprst_pkg::OFS_VECTOR:  prdata <= vector;
					default:                 prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule : dsprst_top

// File: hdl/dsprst_pkg.sv
// Constants for the reset sequencer and flag pin control block
// Functional notes
// - Direction bit 1 controls flag pin zero, bit 5 controls flag pin one.
// - Input flag pins report their sampled level in bit 3 and bit 7.
// - Output flag pins drive the value of bit 2 and bit 6.
// - Input-to-output change starts driving after the next second-phase rising edge.
// - Output-to-input change releases after second-phase rise, then samples on first-phase fall.
// - Reset pin may change anytime; it is synchronised, possibly one cycle later.
// - During reset flag, serial and timer pins go high impedance.
// - During reset both data buses float after a first-phase rising edge.
// - During reset both address buses float after a second-phase rising edge.
// - During reset all three strobes go high after a second-phase rising edge.
// - During reset interrupt acknowledge goes high after a first-phase rising edge.
// - During reset both read/write direction outputs float.
// - Reset loads seven wait states into both bus control registers.
// - Bus hold request is asynchronous and accepted even during reset.
// - Microprocessor mode: reset vector fetched twice, seven wait states each.
// - Microcomputer mode: reset vector fetched twice with zero wait states.
// - Both clock phases derive from rising edges of the input clock.
package dsprst_pkg;
	// Register byte offsets on the APB
	localparam logic [7:0] OFS_IOFLAG   = 8'h00;
	localparam logic [7:0] OFS_PBUSCTL  = 8'h04;
	localparam logic [7:0] OFS_XBUSCTL  = 8'h08;
	localparam logic [7:0] OFS_STATUS   = 8'h0C;
	localparam logic [7:0] OFS_VECTOR   = 8'h10;
	localparam int         REG_AW       = 8;

	// Flag register bit positions, pin zero; pin one is four above
	localparam int FLAG_DIR_POS  = 1;
	localparam int FLAG_OUT_POS  = 2;
	localparam int FLAG_IN_POS   = 3;
	localparam int FLAG_STRIDE   = 4;
	localparam int FLAG_PINS     = 2;

	// Bus control wait-state field
	localparam int         WAIT_W       = 3;
	localparam logic [2:0] WAIT_RESET   = 3'h7;
	localparam logic [2:0] WAIT_MCMODE  = 3'h0;

	// Reset sequencing
	localparam logic [3:0] RESET_MIN_H1 = 4'hA;
	localparam logic [1:0] VECTOR_FETCHES = 2'h2;
	localparam logic [23:0] VECTOR_ADDR = 24'h000000;
	localparam logic [7:0] IOFLAG_RESET = 8'h00;

	// Serial clock/data/sync pins of both ports plus two timer clocks
	localparam int ASYNC_PINS = 14;

	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_FETCH = 2'b01,
		ST_GAP   = 2'b10,
		ST_RUN   = 2'b11
	} dsprst_state_t;
endpackage : dsprst_pkg

// File: hdl/dsprst_phase_if.sv
// Clock phase strobes shared between the phase generator and the sequencer
`timescale 1ns/100ps
interface dsprst_phase_if;
	logic h1;
	logic h3;
	logic h1Rise;
	logic h1Fall;
	logic h3Rise;

	modport gen (output h1, output h3, output h1Rise, output h1Fall, output h3Rise);
	modport use_ (input h1, input h3, input h1Rise, input h1Fall, input h3Rise);
endinterface : dsprst_phase_if

// File: hdl/dsprst_phase_gen.sv
// Two-phase clock generator derived from the input clock
`timescale 1ns/100ps
module dsprst_phase_gen (
	// Clock, reset, enable
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  ce,
	// Phase strobes
	dsprst_phase_if.gen ph
);
	logic phase;

	// Phases toggle on input clock rising edges
	always_ff @(posedge clk) begin
		if (rst) begin
			phase     <= 1'b0;
			ph.h1     <= 1'b0;
			ph.h3     <= 1'b1;
			ph.h1Rise <= 1'b0;
			ph.h1Fall <= 1'b0;
			ph.h3Rise <= 1'b0;
		end else if (ce) begin
			phase     <= ~phase;
			ph.h1     <= ~phase;
			ph.h3     <= phase;
			ph.h1Rise <= ~phase;
			ph.h1Fall <= phase;
			ph.h3Rise <= phase;
		end
	end
endmodule : dsprst_phase_gen

// File: tb/dsprst_monitor.sv
// Checker for the reset sequencer pin states
`timescale 1ns/100ps
module dsprst_monitor (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Reset, hold and strobe pins
	input wire logic        resetN,
	input wire logic        holdN,
	input wire logic        holdAckN,
	input wire logic        iackN,
	input wire logic        strobeN,
	input wire logic        mStrobeN,
	input wire logic        ioStrobeN,
	// Pin enables and address
	input wire logic [1:0]  flagOe,
	input wire logic [13:0] asyncOe,
	input wire logic [23:0] pAddr,
	input wire logic        pAddrOe,
	input wire logic        pDataOe,
	input wire logic        pRwOe,
	input wire logic        xAddrOe,
	input wire logic        xDataOe,
	input wire logic        xRwOe
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_flag_float: assert property ((!resetN)[*5] |-> flagOe == 2'h0)
		else $error("flag pin driven in reset");
	chk_async_float: assert property ((!resetN)[*5] |-> asyncOe == 14'h0)
		else $error("serial or timer pin driven in reset");
	chk_data_float: assert property ((!resetN)[*8] |-> !pDataOe && !xDataOe)
		else $error("data bus driven in reset");
	chk_addr_float: assert property ((!resetN)[*8] |-> !pAddrOe && !xAddrOe)
		else $error("address bus driven in reset");
	chk_strobe_high: assert property ((!resetN)[*8] |-> strobeN && mStrobeN && ioStrobeN)
		else $error("strobe active in reset");
	chk_interrupt_acknowledge_out_high: assert property ((!resetN)[*8] |-> iackN)
		else $error("acknowledge active in reset");
	chk_rw_float: assert property ((!resetN)[*8] |-> !(pRwOe || xRwOe))
		else $error("direction output driven in reset");
	chk_hold_grant: assert property ((!holdN && !resetN)[*5] |-> !holdAckN)
		else $error("hold refused in reset");
	chk_release_sync: assert property ($rose(resetN) |-> strobeN[*3])
		else $error("fetch began before release was synchronised");
	chk_fetch_addr: assert property (!strobeN |-> pAddr == 24'h0)
		else $error("fetch address not the vector");

	cover property ($rose(resetN));
	cover property ($fell(strobeN));
	cover property (!holdAckN && !resetN);
endmodule : dsprst_monitor

bind dsprst_top dsprst_monitor uMon (.clk(clk), .rst(rst), .resetN(resetN), .holdN(holdN),
	.holdAckN(holdAckN), .iackN(iackN), .strobeN(strobeN), .mStrobeN(mStrobeN),
	.ioStrobeN(ioStrobeN), .flagOe(flagOe), .asyncOe(asyncOe), .pAddr(pAddr),
	.pAddrOe(pAddrOe), .pDataOe(pDataOe), .pRwOe(pRwOe), .xAddrOe(xAddrOe),
	.xDataOe(xDataOe), .xRwOe(xRwOe));

// File: tb/dsprst_partner.sv
// Outside system logic: reset, hold and reset vector memory
`timescale 1ns/100ps
module dsprst_partner #(
	parameter logic [31:0] VEC = 32'h00C0FFEE
) (
	// Clock and bench requests
	input wire logic  clk,
	input wire logic  rstReq,
	input wire logic  holdReq,
	// Device side
	input wire logic  strobeN,
	output logic        resetN,
	output logic        holdN,
	output logic [31:0] pDataIn
);
	logic [4:0] lowCnt;

	initial begin
		resetN = 1'b0;
		holdN = 1'b1;
		pDataIn = 32'h0;
		lowCnt = 5'h0;
	end
	// Reset stays low twelve phase-one cycles past the request
	always @(posedge clk) begin
		if (rstReq) begin
			resetN <= 1'b0;
			lowCnt <= 5'h0;
		end else if (lowCnt < 5'h18) begin
			lowCnt <= lowCnt + 5'h1;
		end else begin
			resetN <= 1'b1;
		end
	end
	// Undriven memory data keeps toggling
	always @(posedge clk) begin
		holdN <= !holdReq;
		pDataIn <= strobeN ? ~pDataIn : VEC;
	end
endmodule : dsprst_partner

// File: tb/dsprst_tb_top.sv
// Self-checking bench for the reset sequencer and flag pins
`timescale 1ns/100ps
module dsprst_tb_top;
	localparam logic [31:0] VEC = 32'h00C0FFEE;
	logic        clk, rst, ce, resetN, holdN, mcMode, holdAckN, iackReq, strobeN, iackN;
	logic        psel, penable, pwrite, pready, pslverr, rstReq, holdReq, lastStb;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, pDataIn, v;
	logic [1:0]  flagIn, flagOut, flagOe, d, fi;
	logic [13:0] perOut, perOe, asyncOut, asyncOe;
	logic [32:0] expQ[$];
	int          fails, totalChecks, cyc, lowCnt, rises, lowMode[2];

	dsprst_top uut (.clk(clk), .rst(rst), .ce(ce), .resetN(resetN), .holdN(holdN),
		.mcMode(mcMode), .holdAckN(holdAckN), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flagIn(flagIn), .flagOut(flagOut), .flagOe(flagOe),
		.perOut(perOut), .perOe(perOe), .asyncOut(asyncOut), .asyncOe(asyncOe),
		.iackReq(iackReq), .iackN(iackN), .pAddr(), .pAddrOe(), .pDataIn(pDataIn),
		.pDataOut(), .pDataOe(),
		.pRw(), .pRwOe(), .strobeN(strobeN), .mStrobeN(), .ioStrobeN(), .xAddr(),
		.xAddrOe(), .xDataOut(), .xDataOe(), .xRw(), .xRwOe());
	dsprst_partner #(.VEC(VEC)) uPart (.clk(clk), .rstReq(rstReq), .holdReq(holdReq),
		.strobeN(strobeN), .resetN(resetN), .holdN(holdN), .pDataIn(pDataIn));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		input logic [32:0] e);
		if (!w) expQ.push_back(e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Read results, strobe lengths and the run limit
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) begin
			check({pslverr, prdata}, expQ.pop_front());
		end
		lastStb <= strobeN;
		if (!strobeN) lowCnt++;
		if (strobeN && !lastStb) rises++;
		cyc++;
		if (cyc > 5000) begin
			fails++;
			end_of_test();
		end
	end

	initial begin
		{rst, ce, rstReq, lastStb} = 4'hF;
		{mcMode, psel, penable, pwrite, holdReq, iackReq} = 6'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		flagIn = 2'h2;
		{perOut, perOe} = 28'h0;
		v = 32'h53;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, dsprst_pkg::OFS_PBUSCTL, 32'h0, 33'h7);
		apb(1'b1, dsprst_pkg::OFS_PBUSCTL, 32'h0, 33'h0);
		apb(1'b0, dsprst_pkg::OFS_PBUSCTL, 32'h0, 33'h7);
		apb(1'b0, dsprst_pkg::OFS_XBUSCTL, 32'h0, 33'h7);
		apb(1'b0, dsprst_pkg::OFS_IOFLAG, 32'h0, 33'h80);
		apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
		holdReq <= 1'b1;
		repeat (6) @(posedge clk);
		check({32'h0, holdAckN}, 33'h0);
		holdReq <= 1'b0;
		for (int m = 0; m < 2; m++) begin
			mcMode <= m[0];
			rstReq <= 1'b1;
			repeat (4) @(posedge clk);
			rstReq <= 1'b0;
			lowCnt = 0;
			rises = 0;
			while (rises < 2) @(posedge clk);
			lowMode[m] = lowCnt;
			apb(1'b0, dsprst_pkg::OFS_VECTOR, 32'h0, {1'b0, VEC});
			apb(1'b0, dsprst_pkg::OFS_STATUS, 32'h0, {1'b0, 28'h64, m[0], 2'h0});
		end
		check(33'(lowMode[0] - lowMode[1]), 33'h1C);
		apb(1'b1, dsprst_pkg::OFS_PBUSCTL, 32'h3, 33'h0);
		apb(1'b0, dsprst_pkg::OFS_PBUSCTL, 32'h0, 33'h3);
		repeat (6) begin
			v = xs(v);
			d = {v[6], v[5]};
			fi = (flagIn & d) | (v[3:2] & ~d);
			flagIn <= fi;
			{perOut, perOe, iackReq} <= {v[27:14], v[31:18], v[7]};
			apb(1'b1, dsprst_pkg::OFS_IOFLAG, {24'h0, fi[1], v[1], d[1], 1'b0,
				fi[0], v[0], d[0], 1'b0}, 33'h0);
			repeat (8) @(posedge clk);
			check({31'h0, flagOe}, {31'h0, d});
			check({31'h0, flagOut & d}, {31'h0, v[1:0] & d});
			check({5'h0, asyncOut, asyncOe}, {5'h0, v[27:14], v[31:18]});
			check({32'h0, iackN}, {32'h0, ~v[7]});
			apb(1'b0, dsprst_pkg::OFS_IOFLAG, 32'h0, {25'h0, fi[1], v[1], d[1], 1'b0,
				fi[0], v[0], d[0], 1'b0});
		end
		rstReq <= 1'b1;
		repeat (8) @(posedge clk);
		check({5'h0, asyncOut, asyncOe}, {5'h0, v[27:14], 14'h0});
		check({31'h0, flagOe}, 33'h0);
		check({32'h0, iackN}, 33'h1);
		apb(1'b0, dsprst_pkg::OFS_IOFLAG, 32'h0, {25'h0, fi[1], 3'h0, fi[0], 3'h0});
		end_of_test();
	end
endmodule : dsprst_tb_top
